/* vector_number_format_converter.sv */
// Vector number format converter with rounding, overflow and latency control
`timescale 1ns/1ps
`default_nettype none
`include "vnfc_defines.svh"
module vector_number_format_converter
    import vnfc_pkg::*;
(
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       resetn,
    // Register port
    input  wire logic [`ADDR_W-1:0]         reg_addr,
    input  wire logic [`DATA_W-1:0]         reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [`DATA_W-1:0]         reg_rdata,
    // Sample stream
    input  wire logic                       en,
    input  wire logic                       in_valid,
    input  wire logic [`LANES*`IN_W-1:0]    din,
    output logic                            out_valid,
    output logic      [`LANES*`FLT_W-1:0]   dout
);
    localparam int parallel_lane_count = `LANES;
    localparam int LAT  = `LATENCY;
    localparam int CORE = (LAT == 0) ? 0 : ((`PIPELINE == 0) ? 1 :
                          ((LAT < `CORE_MAX) ? LAT : `CORE_MAX));
    localparam int TAIL = LAT - CORE;
    localparam int D    = `DROP;
    localparam int RW   = `RND_W;
    localparam int OW   = `OUT_W;
    localparam int FW   = `FLT_W;
    localparam int XW   = `IN_W;

    // Output range limits and rounding offsets
    localparam logic signed [RW-1:0] SMAX = RW'((1 << (OW - 1)) - 1);
    localparam logic signed [RW-1:0] SMIN = ~SMAX;
    localparam logic signed [RW-1:0] UMAX = RW'((1 << OW) - 1);
    localparam logic [XW:0]          HALF = (XW+1)'(1 << (D - 1));
    localparam logic [XW:0]          ONE  = (XW+1)'(1);

    logic [`DATA_W-1:0]                  ctrl_r;
    logic                                ovf_seen_r;
    logic [`DATA_W-1:0]                  rdata_nxt;
    out_type_t                           otype_c;
    quant_t                              quant_c;
    ovf_t                                ovf_c;
    flt_t                                fmt_c;
    logic                                sgn_c;
    out_type_t                           otype_a;
    ovf_t                                ovf_a;
    logic                                sgn_a;
    logic [parallel_lane_count-1:0][XW-1:0] x_c;
    logic [parallel_lane_count-1:0][RW-1:0] r_c;
    logic [parallel_lane_count-1:0][RW-1:0] r_a;
    logic [parallel_lane_count-1:0][FW-1:0] flt_c;
    logic [parallel_lane_count-1:0][FW-1:0] flt_a;
    logic [parallel_lane_count-1:0]      bool_c;
    logic [parallel_lane_count-1:0]      bool_a;
    logic [parallel_lane_count-1:0]      hi_b;
    logic [parallel_lane_count-1:0]      lo_b;
    logic [parallel_lane_count-1:0]      ovf_b;
    logic [parallel_lane_count-1:0][OW-1:0] fx_b;
    logic [parallel_lane_count-1:0][FW-1:0] w_b;
    logic [parallel_lane_count-1:0][FW-1:0] core_q;
    logic [parallel_lane_count-1:0][FW-1:0] out_q;
    logic                                vld_b;

    // Mode fields as seen by the first stage
    assign otype_c = out_type_t'(ctrl_r[`CTRL_TYPE]);
    assign sgn_c   = ctrl_r[`CTRL_SGN];
    assign quant_c = quant_t'(ctrl_r[`CTRL_QNT]);
    assign ovf_c   = ovf_t'(ctrl_r[`CTRL_OVF]);
    assign fmt_c   = flt_t'(ctrl_r[`CTRL_FMT]);

    // Control register write
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            ctrl_r <= `CTRL_RST;
        else if (reg_wr && reg_addr == `CTRL_OFS)
            ctrl_r <= reg_wdata;
    end

    // Sticky overflow seen; a new event beats a clear in the same cycle
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            ovf_seen_r <= 1'b0;
        else if (en && vld_b && (|ovf_b))
            ovf_seen_r <= 1'b1;
        else if (reg_wr && reg_addr == `STAT_OFS && reg_wdata[`STAT_OVF])
            ovf_seen_r <= 1'b0;
    end

    // Read mux; data only in the cycle after the strobe
    always_comb
    begin
        rdata_nxt = '0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                `CTRL_OFS: rdata_nxt = ctrl_r;
                `STAT_OFS: rdata_nxt[`STAT_OVF] = ovf_seen_r;
                `INFO_OFS:
                begin
                    rdata_nxt[`INFO_LANES] = 8'(parallel_lane_count);
                    rdata_nxt[`INFO_LAT]   = 8'(LAT);
                    rdata_nxt[`INFO_PIPE]  = (`PIPELINE != 0);
                end
                default:   rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= '0;
        else
            reg_rdata <= rdata_nxt;
    end

    // Per-lane conversion, identical settings on every lane
    for (genvar g = 0; g < parallel_lane_count; g++)
    begin : g_lane
        logic [XW:0] ext;
        logic [XW:0] add;
        logic [XW:0] sum;

        assign x_c[g] = din[g*XW +: XW];
        assign ext    = {x_c[g][XW-1], x_c[g]};

        // Rounding offset added before the low bits are dropped
        always_comb
        begin
            unique case (quant_c)
                Q_SYM:   add = HALF - {{XW{1'b0}}, x_c[g][XW-1]};
                Q_CONV:  add = HALF - ONE + {{XW{1'b0}}, x_c[g][D]};
                default: add = '0;
            endcase
        end

        assign sum    = ext + add;
        assign r_c[g] = sum[XW:D];
        assign bool_c[g] = |x_c[g];

        float_encoder u_flt
        (
            .x   (x_c[g]),
            .fmt (fmt_c),
            .y   (flt_c[g])
        );

        // Range compare for saturation
        assign hi_b[g]  = sgn_a ? ($signed(r_a[g]) > SMAX) : ($signed(r_a[g]) > UMAX);
        assign lo_b[g]  = sgn_a ? ($signed(r_a[g]) < SMIN) : r_a[g][RW-1];
        assign ovf_b[g] = (otype_a == OT_FIXED) && (hi_b[g] || lo_b[g]);

        // Clamp, or keep the low bits for wrap and report modes
        always_comb
        begin
            fx_b[g] = r_a[g][OW-1:0];
            if (ovf_a == OV_SAT && hi_b[g])
                fx_b[g] = sgn_a ? SMAX[OW-1:0] : UMAX[OW-1:0];
            else if (ovf_a == OV_SAT && lo_b[g])
                fx_b[g] = sgn_a ? SMIN[OW-1:0] : '0;
        end

        // Lane word by output type
        always_comb
        begin
            unique case (otype_a)
                OT_BOOL:  w_b[g] = {{(FW-1){1'b0}}, bool_a[g]};
                OT_FIXED: w_b[g] = sgn_a ? {{(FW-OW){fx_b[g][OW-1]}}, fx_b[g]}
                                         : {{(FW-OW){1'b0}}, fx_b[g]};
                OT_FLOAT: w_b[g] = flt_a[g];
                default:  w_b[g] = '0;
            endcase
        end

        assign dout[g*FW +: FW] = out_q[g];
    end

    // Inner pipeline stage between rounding and overflow handling
    if (CORE == 2)
    begin : g_stage_a
        always_ff @(posedge mclk or negedge resetn)
        begin
            if (!resetn)
            begin
                r_a     <= '0;
                flt_a   <= '0;
                bool_a  <= '0;
                otype_a <= OT_BOOL;
                ovf_a   <= OV_SAT;
                sgn_a   <= 1'b0;
            end
            else if (en)
            begin
                r_a     <= r_c;
                flt_a   <= flt_c;
                bool_a  <= bool_c;
                otype_a <= otype_c;
                ovf_a   <= ovf_c;
                sgn_a   <= sgn_c;
            end
        end
    end
    else
    begin : g_no_stage_a
        assign r_a     = r_c;
        assign flt_a   = flt_c;
        assign bool_a  = bool_c;
        assign otype_a = otype_c;
        assign ovf_a   = ovf_c;
        assign sgn_a   = sgn_c;
    end

    // Core output register
    if (CORE >= 1)
    begin : g_core_out
        always_ff @(posedge mclk or negedge resetn)
        begin
            if (!resetn)
                core_q <= '0;
            else if (en)
                core_q <= w_b;
        end
    end
    else
    begin : g_core_wire
        assign core_q = w_b;
    end

    // Remaining latency as a shift register after the core
    if (TAIL > 0)
    begin : g_tail
        logic [parallel_lane_count-1:0][FW-1:0] sr_r [TAIL];
        always_ff @(posedge mclk or negedge resetn)
        begin
            if (!resetn)
            begin
                for (int i = 0; i < TAIL; i++)
                    sr_r[i] <= '0;
            end
            else if (en)
            begin
                sr_r[0] <= core_q;
                for (int i = 1; i < TAIL; i++)
                    sr_r[i] <= sr_r[i-1];
            end
        end
        assign out_q = sr_r[TAIL-1];
    end
    else
    begin : g_no_tail
        assign out_q = core_q;
    end

    // Valid travels beside the data, shared by all lanes
    if (LAT > 0)
    begin : g_valid
        logic [LAT-1:0] vld_r;
        always_ff @(posedge mclk or negedge resetn)
        begin
            if (!resetn)
                vld_r <= '0;
            else if (en)
                vld_r <= LAT'({vld_r, in_valid});
        end
        assign out_valid = vld_r[LAT-1];
        assign vld_b     = (CORE == 2) ? vld_r[0] : in_valid;
    end
    else
    begin : g_no_valid
        assign out_valid = in_valid;
        assign vld_b     = in_valid;
    end

    // Checking helpers: rounding error of lane 0 and a run of enables
    localparam logic signed [XW+1:0] HALF_S = (XW+2)'(1 << (D - 1));
    logic signed [XW+1:0] err0;
    logic [3:0]           en_run_r;

    assign err0 = $signed({x_c[0][XW-1], x_c[0][XW-1], x_c[0]})
                - ($signed({r_c[0][RW-1], r_c[0]}) <<< D);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            en_run_r <= '0;
        else if (!en)
            en_run_r <= '0;
        else if (en_run_r != 4'hF)
            en_run_r <= en_run_r + 4'h1;
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    sequence s_idle;
        !en;
    endsequence
    sequence s_fixed_b;
        en && otype_a == OT_FIXED;
    endsequence
    sequence s_sat_hi;
        s_fixed_b ##0 (ovf_a == OV_SAT && sgn_a && hi_b[0]);
    endsequence

    property p_hold;
        s_idle |=> $stable(dout) && $stable(out_valid);
    endproperty
    a_hold: assert property (p_hold)
        else $error("output changed while enable low");

    property p_latency;
        (en_run_r >= 4'(LAT)) |-> (out_valid == $past(in_valid, LAT));
    endproperty
    a_latency: assert property (p_latency)
        else $error("valid not delayed by the set latency");

    property p_trunc;
        (quant_c == Q_TRUNC) |-> (err0 >= 0 && err0 < (HALF_S <<< 1));
    endproperty
    a_trunc: assert property (p_trunc)
        else $error("truncation result not the floor");

    property p_sym;
        (quant_c == Q_SYM) |-> (err0 <= HALF_S && err0 >= -HALF_S
            && (err0 != HALF_S || x_c[0][XW-1]) && (err0 != -HALF_S || !x_c[0][XW-1]));
    endproperty
    a_sym: assert property (p_sym)
        else $error("symmetric round wrong at midpoint or range");

    property p_conv;
        (quant_c == Q_CONV) |-> (err0 <= HALF_S && err0 >= -HALF_S
            && ((err0 != HALF_S && err0 != -HALF_S) || !r_c[0][0]));
    endproperty
    a_conv: assert property (p_conv)
        else $error("convergent round midpoint not even");

    property p_sat;
        s_sat_hi |=> (core_q[0][OW-1:0] == SMAX[OW-1:0]);
    endproperty
    a_sat: assert property (p_sat)
        else $error("positive overflow not clamped to maximum");

    property p_wrap;
        (s_fixed_b ##0 ovf_a == OV_WRAP) |=> (core_q[0][OW-1:0] == $past(r_a[0][OW-1:0]));
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap did not keep the low bits");

    property p_report;
        (s_fixed_b ##0 (ovf_a == OVERFLOW_REPORT_SIM_ONLY && ovf_b[0]))
            |=> (core_q[0][OW-1:0] == $past(r_a[0][OW-1:0]));
    endproperty
    a_report: assert property (p_report)
        else $error("report mode differs from wrap");

    property p_unsigned;
        (s_fixed_b ##0 (ovf_a == OV_SAT && !sgn_a && r_a[0][RW-1])) |=> (core_q[0] == '0);
    endproperty
    a_unsigned: assert property (p_unsigned)
        else $error("negative value not clamped to zero when unsigned");

    property p_bool;
        (en && otype_a == OT_BOOL) |=> (core_q[0] == {{(FW-1){1'b0}}, $past(bool_a[0])});
    endproperty
    a_bool: assert property (p_bool)
        else $error("Boolean output not the nonzero test");

    property p_float_sign;
        (fmt_c == F_SINGLE && x_c[0][XW-1]) |-> flt_c[0][`SGL_EXP_W+`SGL_FRAC_W];
    endproperty
    a_float_sign: assert property (p_float_sign)
        else $error("single float sign bit wrong");

    property p_sticky;
        (en && vld_b && (|ovf_b)) |=> ovf_seen_r;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("overflow not recorded in status");

    property p_rd_unmapped;
        (reg_rd && reg_addr != `CTRL_OFS && reg_addr != `STAT_OFS && reg_addr != `INFO_OFS)
            |=> (reg_rdata == '0);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* vnfc_defines.svh */
// Constants for the vector number format converter
`ifndef VNFC_DEFINES_SVH
`define VNFC_DEFINES_SVH

// Vector shape and fixed-point formats
`define LANES       4
`define IN_W        24
`define IN_FRAC     12
`define OUT_W       16
`define OUT_FRAC    8
`define DROP        (`IN_FRAC - `OUT_FRAC)
`define RND_W       (`IN_W + 1 - `DROP)
`define LEAD_W      5

// Floating-point formats
`define FLT_W       64
`define SGL_EXP_W   8
`define SGL_FRAC_W  23
`define DBL_EXP_W   11
`define DBL_FRAC_W  52
`define CUS_EXP_W   6
`define CUS_FRAC_W  9
`define SGL_BIAS    ((1 << (`SGL_EXP_W - 1)) - 1)
`define DBL_BIAS    ((1 << (`DBL_EXP_W - 1)) - 1)
`define CUS_BIAS    ((1 << (`CUS_EXP_W - 1)) - 1)

// Latency in sample periods and pipelining
`define LATENCY     3
`define PIPELINE    1
`define CORE_MAX    2

// Register port
`define ADDR_W      4
`define DATA_W      32
`define CTRL_OFS    4'h0
`define STAT_OFS    4'h4
`define INFO_OFS    4'h8
`define CTRL_RST    32'h0000_0025
`define CTRL_TYPE   1:0
`define CTRL_SGN    2
`define CTRL_QNT    4:3
`define CTRL_OVF    6:5
`define CTRL_FMT    8:7
`define STAT_OVF    0
`define INFO_LANES  7:0
`define INFO_LAT    15:8
`define INFO_PIPE   16

`endif

/* vnfc_pkg.sv */
// Types for the vector number format converter
`default_nettype none
package vnfc_pkg;
    typedef enum logic [1:0] {
        OT_BOOL  = 2'b00,
        OT_FIXED = 2'b01,
        OT_FLOAT = 2'b10
    } out_type_t;
    typedef enum logic [1:0] {
        Q_TRUNC = 2'b00,
        Q_SYM   = 2'b01,
        Q_CONV  = 2'b10
    } quant_t;
    typedef enum logic [1:0] {
        OV_SAT                   = 2'b00,
        OV_WRAP                  = 2'b01,
        OVERFLOW_REPORT_SIM_ONLY = 2'b10
    } ovf_t;
    typedef enum logic [1:0] {
        F_SINGLE = 2'b00,
        F_DOUBLE = 2'b01,
        F_CUSTOM = 2'b10
    } flt_t;
endpackage
`default_nettype wire

/* float_encoder.sv */
// Fixed-point to floating-point encoder for one lane
`timescale 1ns/1ps
`default_nettype none
`include "vnfc_defines.svh"
module float_encoder
    import vnfc_pkg::*;
(
    // Sample and target format
    input  wire logic [`IN_W-1:0]  x,
    input  wire flt_t              fmt,
    // Packed result, low aligned
    output logic      [`FLT_W-1:0] y
);
    logic                     sgn;
    logic [`IN_W-1:0]         mag;
    logic [`LEAD_W-1:0]       lead;
    logic [`FLT_W-1:0]        norm;
    logic signed [12:0]       e_s;
    logic [12:0]              e_sgl;
    logic [12:0]              e_dbl;
    logic [12:0]              e_cus;

    // Sign and magnitude; the most negative code still fits unsigned
    assign sgn = x[`IN_W-1];
    assign mag = sgn ? (~x + 1'b1) : x;

    // Position of the leading one
    always_comb
    begin
        lead = '0;
        for (int i = 0; i < `IN_W; i++)
        begin
            if (mag[i])
                lead = `LEAD_W'(i);
        end
    end

    // Leading one moved to the top bit, exponent before bias
    assign norm  = {mag, {(`FLT_W - `IN_W){1'b0}}} << (`LEAD_W'(`IN_W - 1) - lead);
    assign e_s   = $signed({8'h00, lead}) - $signed(13'(`IN_FRAC));
    assign e_sgl = e_s + 13'(`SGL_BIAS);
    assign e_dbl = e_s + 13'(`DBL_BIAS);
    assign e_cus = e_s + 13'(`CUS_BIAS);

    // Pack sign, biased exponent and truncated fraction; zero stays zero
    always_comb
    begin
        y = '0;
        if (mag != '0)
        begin
            unique case (fmt)
                F_SINGLE: y[`SGL_EXP_W+`SGL_FRAC_W:0] =
                    {sgn, e_sgl[`SGL_EXP_W-1:0], norm[`FLT_W-2 -: `SGL_FRAC_W]};
                F_DOUBLE: y[`DBL_EXP_W+`DBL_FRAC_W:0] =
                    {sgn, e_dbl[`DBL_EXP_W-1:0], norm[`FLT_W-2 -: `DBL_FRAC_W]};
                F_CUSTOM: y[`CUS_EXP_W+`CUS_FRAC_W:0] =
                    {sgn, e_cus[`CUS_EXP_W-1:0], norm[`FLT_W-2 -: `CUS_FRAC_W]};
                default:  y = '0;
            endcase
        end
    end
endmodule
`default_nettype wire

/* upstream_model.sv */
// Upstream sample source feeding the converter stream port
`timescale 1ns/1ps
`default_nettype none
`include "vnfc_defines.svh"
module upstream_model
    import vnfc_pkg::*;
(
    // Clock
    input  wire logic                    mclk,
    // Stream towards the converter
    output logic                         en,
    output logic                         in_valid,
    output logic      [`LANES*`IN_W-1:0] din
);
    // Idle at time zero: disabled, no sample
    initial
    begin
        en       = 1'b0;
        in_valid = 1'b0;
        din      = '0;
    end

    // Offer one vector for one enabled cycle, then optionally stall
    task automatic send(input logic [`LANES*`IN_W-1:0] v, input int stall);
        @(posedge mclk);
        en       <= 1'b1;
        in_valid <= 1'b1;
        din      <= v;
        @(posedge mclk);
        in_valid <= 1'b0;
        din      <= ~v; // Released lines never keep the old vector
        if (stall > 0)
        begin
            en <= 1'b0;
            repeat (stall) @(posedge mclk);
            en <= 1'b1;
        end
    endtask
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking testbench for the vector number format converter
`timescale 1ns/1ps
`default_nettype none
`include "vnfc_defines.svh"
module tb
    import vnfc_pkg::*;
;
    logic         mclk;
    logic         resetn;
    logic [3:0]   reg_addr;
    logic [31:0]  reg_wdata;
    logic         reg_wr;
    logic         reg_rd;
    logic [31:0]  reg_rdata;
    logic         en;
    logic         in_valid;
    logic [95:0]  din;
    logic         out_valid;
    logic [255:0] dout;
    int           n_errors;
    int           total_checks;
    logic [31:0]  rd;
    logic [95:0]  vfix [2];
    logic [95:0]  vflt;
    logic [255:0] eflt [3];
    logic [255:0] eb;

    // Design and upstream source
    vector_number_format_converter uut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .en(en), .in_valid(in_valid), .din(din), .out_valid(out_valid), .dout(dout));
    upstream_model src (.mclk(mclk), .en(en), .in_valid(in_valid), .din(din));

    // 20 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Compare and count
    task automatic chk(input string name, input logic [255:0] exp, input logic [255:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Register write: one strobe cycle
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Register read: data stands in the cycle after the strobe
    task automatic reg_check(input logic [3:0] a, input logic [31:0] exp, input string name);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(name, {224'h0, exp}, {224'h0, reg_rdata});
    endtask

    // One vector through the pipe: not early, then exactly three enabled edges
    task automatic run_vec(input logic [95:0] v, input int stall, input logic [255:0] exp);
        src.send(v, stall);
        #1 chk("out_valid early", 256'h0, {255'h0, out_valid});
        @(posedge mclk);
        #1 chk("out_valid early", 256'h0, {255'h0, out_valid});
        @(posedge mclk);
        #1 chk("out_valid", 256'h1, {255'h0, out_valid});
        chk("dout", exp, dout);
    endtask

    // Reference fixed conversion, 24.12 signed in, 16.8 out
    function automatic logic [63:0] fix_ref(logic [23:0] x, int sgn, int q, int ov);
        longint v;
        longint r;
        v = longint'($signed(x));
        r = v >>> 4;
        if (q == 1)
            r = (v < 0) ? -((8 - v) >>> 4) : ((v + 8) >>> 4);
        if (q == 2 && ((v & 15) > 8 || ((v & 15) == 8 && r[0])))
            r = r + 1;
        if (ov == 0)
        begin
            if (r > (sgn ? 32767 : 65535))
                r = sgn ? 32767 : 65535;
            if (r < (sgn ? -32768 : 0))
                r = sgn ? -32768 : 0;
        end
        return sgn ? {{48{r[15]}}, r[15:0]} : {48'h0, r[15:0]};
    endfunction

    // Reference over all lanes
    function automatic logic [255:0] vec_ref(logic [95:0] v, int sgn, int q, int ov);
        logic [255:0] e;
        for (int g = 0; g < 4; g++)
            e[64*g +: 64] = fix_ref(v[24*g +: 24], sgn, q, ov);
        return e;
    endfunction

    // Report counts and verdict, then stop
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog against a hung run
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        $display("[FAIL] watchdog expired");
        complete_run;
    end

    // Main sequence
    initial
    begin
        resetn    = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        n_errors  = 0;
        total_checks = 0;
        vfix[0] = {24'h7F_F000, 24'hFF_FFD8, 24'h00_0028, 24'h00_0018};
        vfix[1] = {24'h80_0000, 24'hFF_FFE8, 24'h00_0017, 24'h00_0000};
        vflt    = {24'h00_0800, 24'hFF_E000, 24'h00_0000, 24'h00_1000};
        eflt[0] = {64'h3F00_0000, 64'hC000_0000, 64'h0, 64'h3F80_0000};
        eflt[1] = {64'h3FE0_0000_0000_0000, 64'hC000_0000_0000_0000, 64'h0,
                   64'h3FF0_0000_0000_0000};
        eflt[2] = {64'h3C00, 64'hC000, 64'h0, 64'h3E00};
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        // Register map reset values, read-only and unmapped places
        reg_check(`CTRL_OFS, `CTRL_RST, "ctrl reset");
        reg_check(`STAT_OFS, 32'h0, "status reset");
        reg_check(`INFO_OFS, 32'h0001_0304, "info");
        reg_write(4'hC, 32'hFFFF_FFFF);
        reg_write(`INFO_OFS, 32'h0000_0000);
        reg_check(4'hC, 32'h0, "unmapped read");
        reg_check(`INFO_OFS, 32'h0001_0304, "info after write");
        reg_check(`CTRL_OFS, `CTRL_RST, "ctrl kept");
        // Fixed output over every sign, quantization and overflow mode
        for (int s = 0; s < 2; s++)
            for (int q = 0; q < 3; q++)
                for (int o = 0; o < 3; o++)
                begin
                    reg_write(`CTRL_OFS, 32'(1 + 4 * s + 8 * q + 32 * o));
                    for (int k = 0; k < 2; k++)
                        run_vec(vfix[k], 2 * k, vec_ref(vfix[k], s, q, o));
                end
        // Sticky overflow flag and its clear
        reg_check(`STAT_OFS, 32'h1, "overflow seen");
        reg_write(`STAT_OFS, 32'h1);
        reg_check(`STAT_OFS, 32'h0, "overflow cleared");
        // Boolean output
        reg_write(`CTRL_OFS, 32'h0000_0000);
        for (int k = 0; k < 2; k++)
        begin
            eb = '0;
            for (int g = 0; g < 4; g++)
                eb[64*g] = |vfix[k][24*g +: 24];
            run_vec(vfix[k], 1, eb);
        end
        // Floating output in single, double and custom formats
        for (int f = 0; f < 3; f++)
        begin
            reg_write(`CTRL_OFS, 32'(2 + 128 * f));
            run_vec(vflt, f, eflt[f]);
        end
        complete_run;
    end
endmodule
`default_nettype wire
